// >>> rtl/acc_top.sv
// Calibration engine, coefficient store and result registers
`timescale 1ns/1ns
`default_nettype none
`include "acc_map.svh"
module acc_top
	import acc_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// Register port from the serial logic
	input  wire logic        regWrite,
	input  wire logic        regRead,
	input  wire logic [7:0]  regAddr,
	input  wire logic [23:0] regWdata,
	output logic [23:0]      regRdata,
	// Converter control
	output logic             convStart,
	output logic [1:0]       calStimulus,
	output logic [7:0]       filterRate,
	output logic [7:0]       amplifierConfig,
	// Converter data
	input  wire logic        convValid,
	input  wire logic [23:0] convData,
	// Results and status
	output logic             resultValid,
	output logic [2:0]       resultIndex,
	output logic             calBusy,
	output logic             calDone
);
	acc_coef_if coef ();

	logic [7:0]  clockFormatConfig;
	logic [1:0]  systemCoeffSetSelect;
	logic [3:0]  resultDestinationSelect;
	logic [23:0] selfOff;
	logic [23:0] selfGain [8];
	logic [23:0] systemZeroCoeff [2];
	logic [23:0] systemScaleCoeff [2];
	logic [23:0] dataReg [8];
	logic [23:0] resultData;

	acc_state_e  state;
	acc_cmd_e    calCmd;
	logic        calPhase;
	logic [2:0]  calIdx;
	logic        divSat;
	logic [4:0]  divCount;
	logic [50:0] divRem;
	logic [50:0] divDen;
	logic [23:0] divQuot;

	// Address windows for read selection, all but the data window also used by write decode
	logic hitSelfGain;
	logic hitZero;
	logic hitScale;
	logic hitData;

	assign hitSelfGain = regAddr[7:3] == `ACC_SELFGAIN_BASE;
	assign hitZero     = regAddr[7:1] == 7'(`ACC_ZERO_A_OFF >> 1);
	assign hitScale    = regAddr[7:1] == 7'(`ACC_SCALE_A_OFF >> 1);
	assign hitData     = regAddr[7:3] == `ACC_DATA_BASE;

	// Host write decode
	logic wrFilter;
	logic wrAmp;
	logic wrClkFmt;
	logic wrCalStart;
	logic wrSyscSel;
	logic wrDest;
	logic wrSelfOff;
	logic wrSelfGain;
	logic wrZero;
	logic wrScale;
	logic hostSet;

	assign wrFilter   = regWrite && regAddr == `ACC_FILTER_OFF;
	assign wrAmp      = regWrite && regAddr == `ACC_AMP_OFF;
	assign wrClkFmt   = regWrite && regAddr == `ACC_CLKFMT_OFF;
	assign wrCalStart = regWrite && regAddr == `ACC_CALSTART_OFF;
	assign wrSyscSel  = regWrite && regAddr == `ACC_SYSCSEL_OFF;
	assign wrDest     = regWrite && regAddr == `ACC_RESULT_DESTINATION_SELECT_OFF;
	assign wrSelfOff  = regWrite && regAddr == `ACC_SELFOFF_OFF;
	assign wrSelfGain = regWrite && hitSelfGain;
	assign wrZero     = regWrite && hitZero;
	assign wrScale    = regWrite && hitScale;
	assign hostSet    = regAddr[0];

	// Command decode: reserved codes and writes while busy are ignored
	acc_cmd_e cmdCode;
	logic     cmdLegal;
	logic     calAccept;

	assign cmdCode   = acc_cmd_e'(regWdata[2:0]);
	assign cmdLegal  = cmdCode != CMD_RSV2 && cmdCode != CMD_RSV3;
	assign calAccept = wrCalStart && cmdLegal && state == ST_IDLE;

	// Arithmetic on a calibration sample
	acc_wide_t calTrim;
	acc_wide_t calScaled;
	acc_wide_t calSys;
	acc_wide_t divSource;
	logic      calSample;
	logic      calSet;
	logic      calIsGain;

	assign calSample = state == ST_CONV && convValid;
	assign calSet    = calCmd[1];
	assign calIsGain = calCmd[0];
	assign calTrim   = accClamp(53'(accWiden(convData)) - 53'($signed(selfOff)));
	assign calScaled = accScale(calTrim, selfGain[calIdx]);
	assign calSys    = accClamp(53'(calScaled) - 53'($signed(systemZeroCoeff[calSet])));
	// Gain search divides full scale by the measured span
	assign divSource = calCmd[2] ? calSys : calTrim;

	// Coefficient updates from the engine
	logic        calWrOff;
	logic        calWrZero;
	logic        divStep;
	logic        divEnd;
	logic        calWrGain;
	logic        calWrScale;
	logic [23:0] nextQuot;
	logic [23:0] calGainValue;

	assign calWrOff     = calSample && calCmd == CMD_SELF && !calPhase;
	assign calWrZero    = calSample && calCmd[2] && !calIsGain;
	assign divStep      = divRem >= divDen;
	assign nextQuot     = {divQuot[22:0], divStep};
	assign divEnd       = state == ST_DIVIDE && divCount == 5'h00;
	assign calWrGain    = divEnd && !calCmd[2];
	assign calWrScale   = divEnd && calCmd[2];
	// Spans under half scale would need more than twice unity
	assign calGainValue = divSat ? `ACC_GAIN_SAT : nextQuot;

	// Configuration registers steering converter and correction, plus the clock format that is only stored and read back
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			filterRate              <= `ACC_CFG_RESET;
			amplifierConfig         <= `ACC_CFG_RESET;
			clockFormatConfig       <= `ACC_CFG_RESET;
			systemCoeffSetSelect    <= 2'h0;
			resultDestinationSelect <= 4'h0;
		end else begin
			if (wrFilter)
				filterRate <= regWdata[7:0];
			if (wrAmp)
				amplifierConfig <= regWdata[7:0];
			if (wrClkFmt)
				clockFormatConfig <= regWdata[7:0];
			if (wrSyscSel)
				systemCoeffSetSelect <= regWdata[1:0];
			if (wrDest)
				resultDestinationSelect <= regWdata[3:0];
		end
	end

	// Self offset: engine update wins over a host write in the same cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			selfOff <= `ACC_OFF_RESET;
		else if (calWrOff)
			selfOff <= accOffset(53'(accWiden(convData)));
		else if (wrSelfOff)
			selfOff <= regWdata;
	end

	// One self gain per amplifier setting
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < 8; i++)
				selfGain[i] <= `ACC_GAIN_RESET;
		end else if (calWrGain) begin
			selfGain[calIdx] <= calGainValue;
		end else if (wrSelfGain) begin
			selfGain[regAddr[2:0]] <= regWdata;
		end
	end

	// System coefficient sets A and B
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < 2; i++) begin
				systemZeroCoeff[i]  <= `ACC_OFF_RESET;
				systemScaleCoeff[i] <= `ACC_GAIN_RESET;
			end
		end else begin
			if (calWrZero)
				systemZeroCoeff[calSet] <= accOffset(53'(calScaled));
			else if (wrZero)
				systemZeroCoeff[hostSet] <= regWdata;
			if (calWrScale)
				systemScaleCoeff[calSet] <= calGainValue;
			else if (wrScale)
				systemScaleCoeff[hostSet] <= regWdata;
		end
	end

	// Calibration sequencer
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state       <= ST_IDLE;
			calCmd      <= CMD_SELF;
			calPhase    <= 1'b0;
			calIdx      <= 3'h0;
			convStart   <= 1'b0;
			calStimulus <= STIM_INPUT;
			calBusy     <= 1'b0;
			calDone     <= 1'b0;
		end else begin
			convStart <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (calAccept) begin
						calCmd    <= cmdCode;
						calPhase  <= 1'b0;
						// Self calibration always targets the unity gain slot
						calIdx    <= cmdCode == CMD_SELF ? 3'h0 : amplifierConfig[2:0];
						convStart <= 1'b1;
						calBusy   <= 1'b1;
						calDone   <= 1'b0;
						state     <= ST_CONV;
						if (cmdCode == CMD_SELF)
							calStimulus <= STIM_ZERO;
						else if (cmdCode == CMD_PGA)
							calStimulus <= STIM_FULL;
						else
							calStimulus <= STIM_INPUT;
					end
				end
				ST_CONV: begin
					if (convValid) begin
						if (calCmd == CMD_SELF && !calPhase) begin
							calPhase    <= 1'b1;
							calStimulus <= STIM_FULL;
							convStart   <= 1'b1;
						end else if (calCmd[2] && !calIsGain) begin
							calStimulus <= STIM_INPUT;
							calBusy     <= 1'b0;
							calDone     <= 1'b1;
							state       <= ST_IDLE;
						end else begin
							calStimulus <= STIM_INPUT;
							state       <= ST_DIVIDE;
						end
					end
				end
				ST_DIVIDE: begin
					if (divEnd) begin
						calBusy <= 1'b0;
						calDone <= 1'b1;
						state   <= ST_IDLE;
					end
				end
				// Unused state encoding falls back to idle
				default: begin
					state   <= ST_IDLE;
					calBusy <= 1'b0;
				end
			endcase
		end
	end

	// Restoring divider, one quotient bit per cycle
	// Reloaded on every calibration sample; only gain commands use the quotient
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			divRem   <= 51'h0;
			divDen   <= 51'h0;
			divQuot  <= 24'h000000;
			divCount <= 5'h00;
			divSat   <= 1'b0;
		end else if (calSample) begin
			divRem   <= `ACC_DIV_NUM;
			divDen   <= {1'b0, divSource[26:0], 23'h000000};
			divQuot  <= 24'h000000;
			divCount <= `ACC_DIV_STEPS;
			divSat   <= divSource <= `ACC_DIV_MIN;
		end else if (state == ST_DIVIDE) begin
			if (divStep)
				divRem <= divRem - divDen;
			divDen   <= divDen >> 1;
			divQuot  <= nextQuot;
			divCount <= divCount - 5'h01;
		end
	end

	// Coefficients seen by the correction path
	assign coef.selfOff   = selfOff;
	assign coef.selfGain  = selfGain[amplifierConfig[2:0]];
	assign coef.sysEnable = systemCoeffSetSelect == 2'h1 || systemCoeffSetSelect == 2'h2;
	assign coef.sysZero   = systemZeroCoeff[systemCoeffSetSelect[1]];
	assign coef.sysScale  = systemScaleCoeff[systemCoeffSetSelect[1]];

	// Calibration samples never reach the data registers
	acc_correct acc_correct_i (
		.clk         (clk),
		.resetn      (resetn),
		.rawValid    (convValid && state == ST_IDLE),
		.rawData     (convData),
		.destSelect  (resultDestinationSelect),
		.coef        (coef.sink),
		.resultValid (resultValid),
		.resultIndex (resultIndex),
		.resultData  (resultData)
	);

	// Destination data registers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < 8; i++)
				dataReg[i] <= 24'h000000;
		end else if (resultValid) begin
			dataReg[resultIndex] <= resultData;
		end
	end

	// Read selection
	// Command register is write only and reads as zero
	logic [23:0] readMux;
	assign readMux =
		regAddr == `ACC_FILTER_OFF           ? {16'h0000, filterRate} :
		regAddr == `ACC_AMP_OFF              ? {16'h0000, amplifierConfig} :
		regAddr == `ACC_CLKFMT_OFF           ? {16'h0000, clockFormatConfig} :
		regAddr == `ACC_STATUS_OFF           ? {22'h000000, calDone, calBusy} :
		regAddr == `ACC_SYSCSEL_OFF          ? {22'h000000, systemCoeffSetSelect} :
		regAddr == `ACC_RESULT_DESTINATION_SELECT_OFF             ? {20'h00000, resultDestinationSelect} :
		regAddr == `ACC_SELFOFF_OFF          ? selfOff :
		hitSelfGain                          ? selfGain[regAddr[2:0]] :
		hitZero                              ? systemZeroCoeff[regAddr[0]] :
		hitScale                             ? systemScaleCoeff[regAddr[0]] :
		hitData                              ? dataReg[regAddr[2:0]] :
		24'h000000;

	// Read data held until the next read
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			regRdata <= 24'h000000;
		else if (regRead)
			regRdata <= readMux;
	end
endmodule : acc_top
`default_nettype wire

// >>> pkg/acc_map.svh
// Register offsets, field positions, reset values and limits of the calibration unit
// Operation
// - Reset clears offset coefficients and sets every gain coefficient to unity.
// - Coefficients come from calibration commands or from direct host writes.
// - Writing the calibration command picks its type and starts it at once.
// - Result is sysgain times ((raw minus selfoff) times selfgain minus sysoff), to destination.
// - Eight self-gain registers, one per amplifier gain; the selected one is applied.
// - Amplifier gain calibration updates only the selected gain's self-gain register.
// - Code 000 runs two conversions, updates self offset and unity-gain register.
// - Calibration uses the programmed line rejection and rate fields.
// - Two system coefficient sets; select applies set A, set B or neither.
// - Gain codes are unsigned, unity 0x800000, LSB worth two to minus 23.
// - Offset codes are two's complement spanning a quarter of the reference each way.
// - Offset spans a quarter reference each way at quarter output LSB resolution.
// - Gain correction covers half to twice unity.
// - Self calibration switches in internal zero and full scale stimuli.
// - System offset calibration stores the value cancelling the zero-scale input.
// - System gain calibration stores the value mapping full-scale input to full scale.
// - Code 001 runs one conversion and updates the selected gain's register.
// - Code 100 stores system offset into set A, 110 into set B.
// - Code 101 stores system gain into set A, 111 into set B.
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH
`define ACC_FILTER_OFF     8'h08
`define ACC_AMP_OFF        8'h0E
`define ACC_CLKFMT_OFF     8'h11
`define ACC_CALSTART_OFF   8'h18
`define ACC_STATUS_OFF     8'h19
`define ACC_SYSCSEL_OFF    8'h1A
`define ACC_RESULT_DESTINATION_SELECT_OFF       8'h1B
`define ACC_SELFOFF_OFF    8'h20
`define ACC_SELFGAIN_BASE  5'h05
`define ACC_ZERO_A_OFF     8'h30
`define ACC_ZERO_B_OFF     8'h31
`define ACC_SCALE_A_OFF    8'h32
`define ACC_SCALE_B_OFF    8'h33
`define ACC_DATA_BASE      5'h07
`define ACC_RATE_LSB       0
`define ACC_LINE_REJECTION_SELECT_LSB      4
`define ACC_GAINSEL_LSB    0
`define ACC_STAT_BUSY      0
`define ACC_STAT_DONE      1
`define ACC_OFF_RESET      24'h000000
`define ACC_GAIN_RESET     24'h800000
`define ACC_CFG_RESET      8'h00
`define ACC_GAIN_SAT       24'hFFFFFF
`define ACC_Q_MAX          53'sh0000001FFFFFF
`define ACC_Q_MIN          -53'sh0000002000000
`define ACC_OFF_MAX        53'sh00000007FFFFF
`define ACC_OFF_MIN        -53'sh0000000800000
`define ACC_DIV_NUM        51'h0000FFFFFE000000
`define ACC_DIV_MIN        28'sh0FFFFFE
`define ACC_DIV_STEPS      5'h17
`endif

// >>> pkg/acc_pkg.sv
// Types and shared arithmetic of the calibration unit
`default_nettype none
`include "acc_map.svh"
package acc_pkg;
	// Working values carry two fraction bits: quarter output LSBs
	typedef logic signed [27:0] acc_wide_t;
	typedef logic [23:0]        acc_word_t;
	typedef enum logic [2:0] {
		CMD_SELF, CMD_PGA, CMD_RSV2, CMD_RSV3,
		CMD_ZERO_A, CMD_SCALE_A, CMD_ZERO_B, CMD_SCALE_B
	} acc_cmd_e;
	typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_DIVIDE} acc_state_e;
	typedef enum logic [1:0] {STIM_INPUT, STIM_ZERO, STIM_FULL} acc_stim_e;

	// Raw code to quarter units
	function automatic acc_wide_t accWiden(acc_word_t raw);
		return {{2{raw[23]}}, raw, 2'b00};
	endfunction : accWiden

	// Clamp to output range in quarter units, never wrap
	function automatic acc_wide_t accClamp(logic signed [52:0] v);
		if (v > `ACC_Q_MAX)
			return acc_wide_t'(`ACC_Q_MAX);
		else if (v < `ACC_Q_MIN)
			return acc_wide_t'(`ACC_Q_MIN);
		else
			return v[27:0];
	endfunction : accClamp

	// Unsigned gain, unity at bit 23
	function automatic acc_wide_t accScale(acc_wide_t x, acc_word_t g);
		logic signed [52:0] p;
		p = (53'(x) * $signed({29'h0000000, g})) >>> 23;
		return accClamp(p);
	endfunction : accScale

	// Offset coefficient: quarter units limited to 24-bit signed
	function automatic acc_word_t accOffset(logic signed [52:0] v);
		if (v > `ACC_OFF_MAX)
			return 24'h7FFFFF;
		else if (v < `ACC_OFF_MIN)
			return 24'h800000;
		else
			return v[23:0];
	endfunction : accOffset
endpackage : acc_pkg
`default_nettype wire

// >>> pkg/acc_coef_if.sv
// Coefficients handed from the register file to the correction path
`timescale 1ns/1ns
`default_nettype none
interface acc_coef_if;
	logic [23:0] selfOff;
	logic [23:0] selfGain;
	logic [23:0] sysZero;
	logic [23:0] sysScale;
	logic        sysEnable;
	modport source (output selfOff, selfGain, sysZero, sysScale, sysEnable);
	modport sink   (input selfOff, selfGain, sysZero, sysScale, sysEnable);
endinterface : acc_coef_if
`default_nettype wire

// >>> rtl/acc_correct.sv
// Correction chain applied to each normal conversion
`timescale 1ns/1ns
`default_nettype none
module acc_correct
	import acc_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// Raw conversion in
	input  wire logic        rawValid,
	input  wire logic [23:0] rawData,
	input  wire logic [3:0]  destSelect,
	// Coefficients
	acc_coef_if.sink         coef,
	// Corrected result out
	output logic             resultValid,
	output logic [2:0]       resultIndex,
	output logic [23:0]      resultData
);
	acc_wide_t selfTrim;
	acc_wide_t selfScaled;
	acc_wide_t sysTrim;
	acc_wide_t sysScaled;
	logic      destLegal;

	// Each stage saturates, so an overrange input pins at full scale
	assign selfTrim   = accClamp(53'(accWiden(rawData)) - 53'($signed(coef.selfOff)));
	assign selfScaled = accScale(selfTrim, coef.selfGain);
	assign sysTrim    = coef.sysEnable ? accClamp(53'(selfScaled) - 53'($signed(coef.sysZero))) : selfScaled;
	assign sysScaled  = coef.sysEnable ? accScale(sysTrim, coef.sysScale) : sysTrim;
	// Only eight destinations exist; upper codes discard the result
	assign destLegal  = ~destSelect[3];

	// One register stage, drop the two fraction bits
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			resultValid <= 1'b0;
			resultIndex <= 3'h0;
			resultData  <= 24'h000000;
		end else begin
			resultValid <= rawValid && destLegal;
			if (rawValid) begin
				resultIndex <= destSelect[2:0];
				resultData  <= sysScaled[25:2];
			end
		end
	end
endmodule : acc_correct
`default_nettype wire

// >>> testbench/acc_top_asserts.sv
// Port-level assertions for the calibration unit
`timescale 1ns/1ns
`default_nettype none
module acc_top_asserts (
	// Clock and reset
	input wire logic        clk,
	input wire logic        resetn,
	// Register port
	input wire logic        regWrite,
	input wire logic        regRead,
	input wire logic [7:0]  regAddr,
	input wire logic [23:0] regWdata,
	input wire logic [23:0] regRdata,
	// Converter and status
	input wire logic        convStart,
	input wire logic [1:0]  calStimulus,
	input wire logic [7:0]  filterRate,
	input wire logic [7:0]  amplifierConfig,
	input wire logic        convValid,
	input wire logic        resultValid,
	input wire logic        calBusy,
	input wire logic        calDone
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// Command handling and conversion requests
	cmd_start_a: assert property (regWrite && regAddr == 8'h18 && !calBusy && regWdata[2:1] != 2'b01
		|=> calBusy && convStart && !calDone) else $error("command not started");
	start_pulse_a: assert property (convStart |-> calBusy ##1 !convStart) else $error("bad request pulse");
	rate_copy_a: assert property (regWrite && regAddr == 8'h08 |=> filterRate == $past(regWdata[7:0]))
		else $error("filter setting lost");
	gain_copy_a: assert property (regWrite && regAddr == 8'h0E
		|=> amplifierConfig[2:0] == $past(regWdata[2:0])) else $error("gain select lost");
	// Results only come from normal conversions
	result_cause_a: assert property (resultValid |-> $past(convValid) && !$past(calBusy))
		else $error("result without conversion");
	// Self calibration sequencing
	second_conv_a: assert property (convValid && calBusy && calStimulus == 2'd1
		|=> convStart && calStimulus == 2'd2) else $error("no full scale conversion");
	divide_time_a: assert property (convValid && calBusy && calStimulus == 2'd2 |=> calBusy [*8])
		else $error("gain stored too early");
	// Status behaviour
	done_flag_a: assert property ($fell(calBusy) |-> calDone) else $error("done missing");
	busy_bound_a: assert property ($rose(calBusy) |-> ##[1:1000] !calBusy) else $error("busy stuck");
	status_read_a: assert property (regRead && regAddr == 8'h19
		|=> regRdata == {22'h0, $past(calDone), $past(calBusy)}) else $error("status read wrong");
	unmapped_read_a: assert property (regRead && regAddr == 8'hFF |=> regRdata == 24'h0)
		else $error("unmapped read not zero");
endmodule : acc_top_asserts
bind acc_top acc_top_asserts acc_top_asserts_i (.clk(clk), .resetn(resetn), .regWrite(regWrite),
	.regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .convStart(convStart),
	.calStimulus(calStimulus), .filterRate(filterRate), .amplifierConfig(amplifierConfig),
	.convValid(convValid), .resultValid(resultValid), .calBusy(calBusy), .calDone(calDone));
`default_nettype wire

// >>> testbench/acc_conv_model.sv
// Converter stand-in answering conversion requests
`timescale 1ns/1ns
`default_nettype none
module acc_conv_model (
	// Clock and reset
	input wire logic        clk,
	input wire logic        resetn,
	// Requests from the calibration unit
	input wire logic        convStart,
	input wire logic [1:0]  calStimulus,
	// Scenario settings
	input wire logic [7:0]  replyDelay,
	input wire logic [23:0] zeroCode,
	input wire logic [23:0] fullCode,
	input wire logic [23:0] inputCode,
	input wire logic        normReq,
	input wire logic [23:0] normData,
	// Conversion out
	output logic            convValid,
	output logic [23:0]     convData
);
	logic [7:0] waitCnt;
	// Word toggles between conversions so a stale capture shows up
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			waitCnt   <= 8'h00;
			convValid <= 1'b0;
			convData  <= 24'h000000;
		end else begin
			convValid <= 1'b0;
			convData  <= ~convData;
			if (convStart)
				waitCnt <= replyDelay;
			else if (waitCnt != 8'h00)
				waitCnt <= waitCnt - 8'h01;
			if (waitCnt == 8'h01) begin
				convValid <= 1'b1;
				// Internal zero and full-scale stimuli, otherwise the external input code
				convData <= (calStimulus == 2'd1) ? zeroCode : (calStimulus == 2'd2) ? fullCode : inputCode;
			end else if (normReq) begin
				convValid <= 1'b1;
				convData  <= normData;
			end
		end
	end
endmodule : acc_conv_model
`default_nettype wire

// >>> testbench/acc_top_tb.sv
// Self-checking bench for the calibration unit
`timescale 1ns/1ns
`default_nettype none
module acc_top_tb;
	logic             clk, resetn, regWrite, regRead, normReq;
	logic [7:0]       regAddr, replyDelay;
	logic [23:0]      regWdata, zeroCode, fullCode, inputCode, normData;
	wire logic [23:0] regRdata, convData;
	wire logic [7:0]  filterRate, amplifierConfig;
	wire logic [2:0]  resultIndex;
	wire logic [1:0]  calStimulus;
	wire logic        convStart, convValid, resultValid, calBusy, calDone;
	int               errorCnt = 0, checkCount = 0, cycles = 0;

	acc_top acc_top_i (.clk(clk), .resetn(resetn), .regWrite(regWrite), .regRead(regRead),
		.regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .convStart(convStart),
		.calStimulus(calStimulus), .filterRate(filterRate), .amplifierConfig(amplifierConfig),
		.convValid(convValid), .convData(convData), .resultValid(resultValid),
		.resultIndex(resultIndex), .calBusy(calBusy), .calDone(calDone));
	acc_conv_model acc_conv_model_i (.clk(clk), .resetn(resetn), .convStart(convStart),
		.calStimulus(calStimulus), .replyDelay(replyDelay), .zeroCode(zeroCode), .fullCode(fullCode),
		.inputCode(inputCode), .normReq(normReq), .normData(normData), .convValid(convValid),
		.convData(convData));

	// Clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Hang guard, far above the few hundred cycles needed
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errorCnt = errorCnt + 1;
			finalReport();
		end
	end

	task automatic chk(input string name, input logic [23:0] e, input logic [23:0] g);
		checkCount++;
		if (g !== e) begin
			errorCnt++;
			$display("mismatch %s expected %h seen %h", name, e, g);
		end
	endtask : chk
	// One register write, strobe for one edge
	task automatic wr(input logic [7:0] a, input logic [23:0] d);
		@(posedge clk);
		regWrite <= 1'b1;
		regAddr  <= a;
		regWdata <= d;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask : wr
	// Read and compare, data sampled one edge after the read edge
	task automatic rc(input logic [7:0] a, input logic [23:0] e);
		@(posedge clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRead <= 1'b0;
		@(posedge clk);
		chk($sformatf("reg %h", a), e, regRdata);
	endtask : rc
	// Start a calibration and wait, bounded, for busy to drop
	task automatic cal(input logic [2:0] code);
		wr(8'h18, {21'h0, code});
		@(posedge clk);
		for (int i = 0; i < 2000 && calBusy !== 1'b0; i++)
			@(posedge clk);
		chk("calBusy", 24'h0, {23'h0, calBusy});
	endtask : cal
	// Normal conversion; returns valid flag and destination index
	task automatic conv(input logic [23:0] d, output logic [3:0] got);
		@(posedge clk);
		normReq  <= 1'b1;
		normData <= d;
		@(posedge clk);
		normReq <= 1'b0;
		got = 4'h0;
		repeat (4) begin
			@(posedge clk);
			if (resultValid === 1'b1)
				got = {1'b1, resultIndex};
		end
	endtask : conv

	task automatic testReset();
		rc(8'h20, 24'h000000);
		for (int i = 0; i < 8; i++)
			rc(8'h28 + 8'(i), 24'h800000);
		rc(8'h30, 24'h000000);
		rc(8'h31, 24'h000000);
		rc(8'h32, 24'h800000);
		rc(8'h33, 24'h800000);
		rc(8'hFF, 24'h000000);
	endtask : testReset

	task automatic testSelf();
		// Slowest rate used here, later conversions no slower
		wr(8'h08, 24'h00003F);
		rc(8'h08, 24'h00003F);
		chk("filterRate", 24'h3F, {16'h0, filterRate});
		replyDelay <= 8'd20;
		zeroCode   <= 24'h000020;
		fullCode   <= 24'h3FFFFF;
		cal(3'd0);
		chk("calDone", 24'h1, {23'h0, calDone});
		rc(8'h19, 24'h000002);
		rc(8'h20, 24'h000080);
		rc(8'h28, 24'hFFFFFF);
		rc(8'h29, 24'h800000);
		// Reserved code must not start anything
		wr(8'h18, 24'h000002);
		@(posedge clk);
		chk("calBusy", 24'h0, {23'h0, calBusy});
	endtask : testSelf

	task automatic testPga();
		// Host path replaces calibrated values
		wr(8'h20, 24'h000000);
		wr(8'h28, 24'h800000);
		rc(8'h28, 24'h800000);
		wr(8'h0E, 24'h000003);
		rc(8'h0E, 24'h000003);
		chk("amplifierConfig", 24'h3, {16'h0, amplifierConfig});
		replyDelay <= 8'd1;
		fullCode   <= 24'h400000;
		cal(3'd1);
		rc(8'h2B, 24'hFFFFFE);
		rc(8'h28, 24'h800000);
		rc(8'h20, 24'h000000);
	endtask : testPga

	task automatic testSys();
		// Inputs routed to the zero level before each offset command
		wr(8'h0E, 24'h000000);
		inputCode <= 24'h000100;
		// A second command while busy is dropped, set B stays clear
		wr(8'h18, 24'h000004);
		wr(8'h18, 24'h000006);
		rc(8'h31, 24'h000000);
		cal(3'd4);
		rc(8'h30, 24'h000400);
		inputCode <= 24'hFFFFF0;
		cal(3'd6);
		rc(8'h31, 24'hFFFFC0);
		// Gain only after offsets are in place
		inputCode <= 24'h100000;
		cal(3'd5);
		rc(8'h32, 24'hFFFFFF);
		rc(8'h33, 24'h800000);
		cal(3'd7);
		rc(8'h33, 24'hFFFFFF);
		rc(8'h30, 24'h000400);
	endtask : testSys

	task automatic testCorrect();
		logic [3:0]  got;
		logic [23:0] expVal [4] = '{24'h001FFF, 24'h003DFF, 24'h00401F, 24'h001FFF};
		wr(8'h0E, 24'h000003);
		wr(8'h1B, 24'h000002);
		// Set select none, A, B, none with the 2x gain slot active
		for (int s = 0; s < 4; s++) begin
			wr(8'h1A, 24'(s));
			conv(24'h001000, got);
			chk("resultIndex", 24'hA, {20'h0, got});
			rc(8'h3A, expVal[s]);
		end
		wr(8'h1A, 24'h000000);
		conv(24'h7FFFFF, got);
		rc(8'h3A, 24'h7FFFFF);
		// Destinations from 8 upwards are dropped
		wr(8'h1B, 24'h000008);
		conv(24'h000010, got);
		chk("discard", 24'h0, {20'h0, got});
		rc(8'h3A, 24'h7FFFFF);
	endtask : testCorrect

	task automatic finalReport();
		$display("checks %0d errors %0d", checkCount, errorCnt);
		if (errorCnt == 0 && checkCount > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finalReport

	// Main sequence
	initial begin
		resetn     = 1'b0;
		regWrite   = 1'b0;
		regRead    = 1'b0;
		regAddr    = 8'h00;
		regWdata   = 24'h000000;
		replyDelay = 8'd1;
		zeroCode   = 24'h000000;
		fullCode   = 24'h000000;
		inputCode  = 24'h000000;
		normReq    = 1'b0;
		normData   = 24'h000000;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		testReset();
		testSelf();
		testPga();
		testSys();
		testCorrect();
		finalReport();
	end
endmodule : acc_top_tb
`default_nettype wire
